// *** design/measurement_start_sequencer.sv ***
// Summary of operation
// RULE1 - a start first switches the backplane clock on before any card is touched.
// RULE2 - next the software trigger of every listed card is cleared, in list order.
// RULE3 - timing registers are reset by taking each card to configuration mode and back to measurement mode.
// RULE4 - configuration goes in list order, measurement mode and trigger arming in reverse list order.
// RULE5 - the keep option holds the backplane clock on during the run, otherwise it is gated off after arming.
// RULE6 - no backplane transfer happens while the backplane clock is gated off.
// RULE7 - status bit 0 is one while the measurement runs and zero once it is ready.
// RULE8 - status bit 1 shows whether the backplane clock is running.
// RULE9 - a card in continuous generation keeps generating until its continuous select is cleared.
// RULE10 - a card in continuous generation ignores its settle and measurement loop counts.
// RULE11 - a stop enables the clock, clears the listed triggers, then sets configuration mode, both in list order.
// RULE12 - each card operation completes before the next one is issued.
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "seq_map.svh"
module measurement_start_sequencer (
  input  wire logic              core_clk,                   // controller clock
  input  wire logic              sys_rst,                    // async reset, high
  input  wire logic [7:0]        s_axi_awaddr,               // write address
  input  wire logic              s_axi_awvalid,              // write address valid
  output logic                   s_axi_awready,              // write address ready
  input  wire logic [31:0]       s_axi_wdata,                // write data
  input  wire logic [3:0]        s_axi_wstrb,                // byte enables
  input  wire logic              s_axi_wvalid,               // write data valid
  output logic                   s_axi_wready,               // write data ready
  output logic [1:0]             s_axi_bresp,                // write response
  output logic                   s_axi_bvalid,               // write response valid
  input  wire logic              s_axi_bready,               // write response ready
  input  wire logic [7:0]        s_axi_araddr,               // read address
  input  wire logic              s_axi_arvalid,              // read address valid
  output logic                   s_axi_arready,              // read address ready
  output logic [31:0]            s_axi_rdata,                // read data
  output logic [1:0]             s_axi_rresp,                // read response
  output logic                   s_axi_rvalid,               // read data valid
  input  wire logic              s_axi_rready,               // read data ready
  input  wire logic              bp_clk,                     // backplane link clock
  output logic                   bp_clk_en,                  // backplane clock gate enable
  output logic                   card_op_valid,              // card operation offered
  input  wire logic              card_op_ready,              // card operation done
  output seq_pkg::card_op_t      card_op_code,               // trigger / mode operation
  output logic [2:0]             card_op_slot,               // target card slot
  output logic [31:0]            card_op_data,               // loop counts for measurement mode
  output logic [7:0]             continuous_generate_select  // per slot continuous mode
);
  import seq_pkg::*;

  // ==========================================================
  // register slave
  logic        aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [7:0]  awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0]  wstrb_q, wstrb_d;
  logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] cards_q, cards_d, loops_q, loops_d;
  logic [7:0]  cont_q, cont_d;
  logic        wr_do, go;
  logic [31:0] status_word;

  seq_state_t  st_q, st_d;
  card_op_t    phase_q, phase_d, op_code_q, op_code_d;
  logic [1:0]  idx_q, idx_d;
  logic        stop_q, stop_d, keep_q, keep_d, run_q, run_d, en_q, en_d, req_q, req_d;
  logic [2:0]  op_slot_q, op_slot_d, slot_cur, cnt;
  logic [31:0] op_data_q, op_data_d;
  logic [2:0]  ack_s_q;
  logic        ack_seen_q, ack_seen_d, ack_evt, last, ack_tgl_q;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = n[8*b +: 8];
      end
    end
    return r;
  endfunction

  assign wr_do       = aw_got_q && w_got_q && !bvalid_q;
  assign go          = wr_do && (awaddr_q == `REG_CTRL) && wstrb_q[0] && (st_q == ST_IDLE);
  assign status_word = {30'h0, en_q, run_q};  // RULE7 RULE8

  always_comb begin
    aw_got_d = aw_got_q;
    w_got_d  = w_got_q;
    awaddr_d = awaddr_q;
    wdata_d  = wdata_q;
    wstrb_d  = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d  = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d  = rresp_q;
    rdata_d  = rdata_q;
    cards_d  = cards_q;
    cont_d   = cont_q;
    loops_d  = loops_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (wr_do) begin
      aw_got_d = 1'b0;
      w_got_d  = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = `RESP_OKAY;
      case (awaddr_q)
        `REG_CTRL:   ;
        `REG_STATUS: ;
        `REG_CARDS:  cards_d = merge(cards_q, wdata_q, wstrb_q);
        `REG_CONT:   cont_d  = wstrb_q[0] ? wdata_q[7:0] : cont_q;  // RULE9
        `REG_LOOPS:  loops_d = merge(loops_q, wdata_q, wstrb_q);
        default:     bresp_d = `RESP_SLVERR;
      endcase
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = `RESP_OKAY;
      case (s_axi_araddr)
        `REG_CTRL:   rdata_d = {30'h0, keep_q, run_q};
        `REG_STATUS: rdata_d = status_word;
        `REG_CARDS:  rdata_d = cards_q;
        `REG_CONT:   rdata_d = {24'h0, cont_q};
        `REG_LOOPS:  rdata_d = loops_q;
        default: begin
          rdata_d = 32'h0;
          rresp_d = `RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= 8'h0;
      wdata_q  <= 32'h0;
      wstrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= `RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q  <= `RESP_OKAY;
      rdata_q  <= 32'h0;
      cards_q  <= `CARDS_RST;
      cont_q   <= `CONT_RST;
      loops_q  <= `LOOPS_RST;
    end else begin
      aw_got_q <= aw_got_d;
      w_got_q  <= w_got_d;
      awaddr_q <= awaddr_d;
      wdata_q  <= wdata_d;
      wstrb_q  <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q  <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q  <= rresp_d;
      rdata_q  <= rdata_d;
      cards_q  <= cards_d;
      cont_q   <= cont_d;
      loops_q  <= loops_d;
    end
  end

  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready  = !w_got_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign continuous_generate_select = cont_q;

  // ==========================================================
  // sequencer, core side
  // list holds up to four 3-bit slots; a count above four is taken as four
  assign cnt      = (cards_q[`CARDS_CNT_LSB +: 3] > 3'd4) ? 3'd4 : cards_q[`CARDS_CNT_LSB +: 3];
  assign slot_cur = cards_q[{2'b00, idx_q} * 4'd3 +: 3];
  assign last     = phase_q[1] ? (idx_q == 2'd0) : ({1'b0, idx_q} == cnt - 3'd1);  // RULE4
  assign ack_evt  = (ack_s_q[1] == ack_s_q[2]) && (ack_s_q[2] != ack_seen_q);

  always_comb begin
    st_d       = st_q;
    phase_d    = phase_q;
    idx_d      = idx_q;
    stop_d     = stop_q;
    keep_d     = keep_q;
    run_d      = run_q;
    en_d       = en_q;
    req_d      = req_q;
    op_code_d  = op_code_q;
    op_slot_d  = op_slot_q;
    op_data_d  = op_data_q;
    ack_seen_d = ack_evt ? ack_s_q[2] : ack_seen_q;
    case (st_q)
      ST_IDLE: begin
        if (go) begin
          stop_d = !wdata_q[`CTRL_RUN_BIT];
          keep_d = wdata_q[`CTRL_KEEP_BIT];
          run_d  = wdata_q[`CTRL_RUN_BIT] | run_q;
          en_d   = 1'b1;  // RULE1 RULE11
          st_d   = ST_CLK_ON;
        end
      end
      ST_CLK_ON: begin
        phase_d = OP_TRIG_CLR;  // RULE2
        idx_d   = 2'd0;
        st_d    = (cnt == 3'd0) ? ST_GATE : ST_ISSUE;
      end
      ST_ISSUE: begin
        op_code_d = phase_q;
        op_slot_d = slot_cur;
        op_data_d = (phase_q == OP_MODE_MEAS && !cont_q[slot_cur]) ? loops_q : 32'h0;  // RULE10
        req_d     = !req_q;
        st_d      = ST_WAIT;
      end
      ST_WAIT: begin
        if (ack_evt) begin  // RULE12
          st_d = ST_ISSUE;
          if (!last) begin
            idx_d = phase_q[1] ? idx_q - 2'd1 : idx_q + 2'd1;  // RULE4
          end else if ((stop_q && phase_q == OP_MODE_CFG) || phase_q == OP_TRIG_SET) begin
            st_d = ST_GATE;  // RULE11
          end else begin
            phase_d = card_op_t'(phase_q + 2'd1);  // RULE3
            // configuration restarts at the head, the two later phases restart at the tail
            idx_d   = (phase_q == OP_TRIG_CLR) ? 2'd0 : 2'(cnt - 3'd1);  // RULE4
          end
        end
      end
      ST_GATE: begin
        if (stop_q) begin
          run_d = 1'b0;  // RULE7
        end else begin
          en_d = keep_q;  // RULE5
        end
        st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q       <= ST_IDLE;
      phase_q    <= OP_TRIG_CLR;
      idx_q      <= 2'd0;
      stop_q     <= 1'b0;
      keep_q     <= 1'b0;
      run_q      <= 1'b0;
      en_q       <= 1'b0;
      req_q      <= 1'b0;
      op_code_q  <= OP_TRIG_CLR;
      op_slot_q  <= 3'd0;
      op_data_q  <= 32'h0;
      ack_s_q    <= 3'd0;
      ack_seen_q <= 1'b0;
    end else begin
      st_q       <= st_d;
      phase_q    <= phase_d;
      idx_q      <= idx_d;
      stop_q     <= stop_d;
      keep_q     <= keep_d;
      run_q      <= run_d;
      en_q       <= en_d;
      req_q      <= req_d;
      op_code_q  <= op_code_d;
      op_slot_q  <= op_slot_d;
      op_data_q  <= op_data_d;
      ack_s_q    <= {ack_s_q[1:0], ack_tgl_q};
      ack_seen_q <= ack_seen_d;
    end
  end

  assign bp_clk_en = en_q;

  // ==========================================================
  // link side on the backplane clock
  // op fields stay still from request toggle until ack, so they cross as quasi-static words
  logic [2:0]  req_s_q, en_s_q;
  logic        req_seen_q, req_seen_d, clk_on_q, clk_on_d, valid_q, valid_d, ack_tgl_d;
  card_op_t    l_code_q, l_code_d;
  logic [2:0]  l_slot_q, l_slot_d;
  logic [31:0] l_data_q, l_data_d;

  always_comb begin
    req_seen_d = req_seen_q;
    valid_d    = valid_q;
    ack_tgl_d  = ack_tgl_q;
    l_code_d   = l_code_q;
    l_slot_d   = l_slot_q;
    l_data_d   = l_data_q;
    clk_on_d   = (en_s_q[1] == en_s_q[2]) ? en_s_q[2] : clk_on_q;
    if (valid_q) begin
      if (card_op_ready) begin
        valid_d   = 1'b0;
        ack_tgl_d = !ack_tgl_q;
      end
    end else if (req_s_q[1] == req_s_q[2] && req_s_q[2] != req_seen_q && clk_on_q) begin  // RULE6
      req_seen_d = req_s_q[2];
      valid_d    = 1'b1;
      l_code_d   = op_code_q;
      l_slot_d   = op_slot_q;
      l_data_d   = op_data_q;
    end
  end

  always_ff @(posedge bp_clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_s_q    <= 3'd0;
      en_s_q     <= 3'd0;
      req_seen_q <= 1'b0;
      clk_on_q   <= 1'b0;
      valid_q    <= 1'b0;
      ack_tgl_q  <= 1'b0;
      l_code_q   <= OP_TRIG_CLR;
      l_slot_q   <= 3'd0;
      l_data_q   <= 32'h0;
    end else begin
      req_s_q    <= {req_s_q[1:0], req_q};
      en_s_q     <= {en_s_q[1:0], en_q};
      req_seen_q <= req_seen_d;
      clk_on_q   <= clk_on_d;
      valid_q    <= valid_d;
      ack_tgl_q  <= ack_tgl_d;
      l_code_q   <= l_code_d;
      l_slot_q   <= l_slot_d;
      l_data_q   <= l_data_d;
    end
  end

  assign card_op_valid = valid_q;
  assign card_op_code  = l_code_q;
  assign card_op_slot  = l_slot_q;
  assign card_op_data  = l_data_q;

  // ==========================================================
  // checks
  sequence s_first_clear;
    (st_q == ST_ISSUE && phase_q == OP_TRIG_CLR && idx_q == 2'd0) ##1 (op_code_q == OP_TRIG_CLR);
  endsequence
  property p_start_clk;
    @(posedge core_clk) disable iff (sys_rst) (st_q == ST_IDLE && go) |=> en_q && st_q == ST_CLK_ON;
  endproperty
  a_start_clk: assert property (p_start_clk) else $error("clock not enabled on start");  // RULE1
  property p_req_clk;
    @(posedge core_clk) disable iff (sys_rst) (req_q != $past(req_q)) |-> en_q;
  endproperty
  a_req_clk: assert property (p_req_clk) else $error("card op issued with clock off");  // RULE1
  property p_clear_first;
    @(posedge core_clk) disable iff (sys_rst) (st_q == ST_CLK_ON && cnt != 3'd0) |=> s_first_clear;
  endproperty
  a_clear_first: assert property (p_clear_first) else $error("first op is not trigger clear");  // RULE2
  property p_fwd_step;
    @(posedge core_clk) disable iff (sys_rst) (st_q == ST_WAIT && ack_evt && !last && !phase_q[1])
      |=> idx_q == $past(idx_q) + 2'd1;
  endproperty
  a_fwd_step: assert property (p_fwd_step) else $error("forward order broken");  // RULE4
  property p_rev_step;
    @(posedge core_clk) disable iff (sys_rst) (st_q == ST_WAIT && ack_evt && !last && phase_q[1])
      |=> idx_q == $past(idx_q) - 2'd1;
  endproperty
  a_rev_step: assert property (p_rev_step) else $error("reverse order broken");  // RULE4
  property p_meas_start;
    @(posedge core_clk) disable iff (sys_rst) (phase_q == OP_MODE_MEAS && $past(phase_q) == OP_MODE_CFG)
      |-> {1'b0, idx_q} == cnt - 3'd1;
  endproperty
  a_meas_start: assert property (p_meas_start) else $error("measurement mode not from last card");  // RULE3
  property p_cfg_start;
    @(posedge core_clk) disable iff (sys_rst) (phase_q == OP_MODE_CFG && $past(phase_q) == OP_TRIG_CLR)
      |-> idx_q == 2'd0;
  endproperty
  a_cfg_start: assert property (p_cfg_start) else $error("configuration not from first card");  // RULE4
  property p_arm_start;
    @(posedge core_clk) disable iff (sys_rst) (phase_q == OP_TRIG_SET && $past(phase_q) == OP_MODE_MEAS)
      |-> {1'b0, idx_q} == cnt - 3'd1;
  endproperty
  a_arm_start: assert property (p_arm_start) else $error("trigger arming not from last card");  // RULE4
  property p_gate;
    @(posedge core_clk) disable iff (sys_rst) (st_q == ST_GATE && !stop_q) |=> en_q == $past(keep_q) && run_q;
  endproperty
  a_gate: assert property (p_gate) else $error("clock gating after arm wrong");  // RULE5
  property p_stop_done;
    @(posedge core_clk) disable iff (sys_rst) (st_q == ST_GATE && stop_q) |=> !run_q && en_q;
  endproperty
  a_stop_done: assert property (p_stop_done) else $error("stop did not end run");  // RULE7
  property p_one_op;
    @(posedge core_clk) disable iff (sys_rst) (st_q == ST_WAIT && !ack_evt) |=> req_q == $past(req_q);
  endproperty
  a_one_op: assert property (p_one_op) else $error("op issued before previous done");  // RULE12
  property p_cont_loops;
    @(posedge core_clk) disable iff (sys_rst) (st_q == ST_ISSUE && cont_q[slot_cur]) |=> op_data_q == 32'h0;
  endproperty
  a_cont_loops: assert property (p_cont_loops) else $error("loop counts sent to continuous card");  // RULE10
  property p_gated_idle;
    @(posedge bp_clk) disable iff (sys_rst) (!clk_on_q && !valid_q) |=> !valid_q;
  endproperty
  a_gated_idle: assert property (p_gated_idle) else $error("transfer while clock gated");  // RULE6
endmodule

// *** pkg/seq_map.svh ***
`ifndef SEQ_MAP_SVH
`define SEQ_MAP_SVH
// register byte offsets
`define REG_CTRL      8'h00
`define REG_STATUS    8'h04
`define REG_CARDS     8'h08
`define REG_CONT      8'h0c
`define REG_LOOPS     8'h10
// field positions
`define CTRL_RUN_BIT  0
`define CTRL_KEEP_BIT 1
`define STAT_RUN_BIT  0
`define STAT_CLK_BIT  1
`define CARDS_CNT_LSB 12
// reset values
`define CARDS_RST     32'h0000_0000
`define CONT_RST      8'h00
`define LOOPS_RST     32'h0000_0000
// axi responses
`define RESP_OKAY     2'b00
`define RESP_SLVERR   2'b10
`endif

// *** pkg/seq_pkg.sv ***
package seq_pkg;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_CLK_ON = 3'b001,
    ST_ISSUE  = 3'b010,
    ST_WAIT   = 3'b011,
    ST_GATE   = 3'b100
  } seq_state_t;
  // op code doubles as sequence phase; bit 1 set means reverse list order
  typedef enum logic [1:0] {
    OP_TRIG_CLR  = 2'b00,
    OP_MODE_CFG  = 2'b01,
    OP_MODE_MEAS = 2'b10,
    OP_TRIG_SET  = 2'b11
  } card_op_t;
endpackage

// *** testbench/card_backplane_model.sv ***
`timescale 1ns/1ps
// ====
// card slots behind the backplane
module card_backplane_model (
  input  wire logic              bp_clk,        // link clock
  input  wire logic              sys_rst,       // async reset, high
  input  wire logic              card_op_valid, // operation offered
  input  seq_pkg::card_op_t      card_op_code,  // operation
  input  wire logic [2:0]        card_op_slot,  // target slot
  input  wire logic [7:0]        cont_sel,      // continuous mode per slot
  output logic                   card_op_ready, // operation done
  output logic [7:0]             gen            // slots generating repeatedly
);
  import seq_pkg::*;
  logic [7:0] meas_q;
  logic [7:0] trig_q;
  int         wait_n;
  // measurement mode plus trigger keeps a continuous card running until its select drops
  assign gen = meas_q & trig_q & cont_sel;
  always @(posedge bp_clk or posedge sys_rst) begin
    if (sys_rst) begin
      card_op_ready <= 1'b0;
      meas_q <= 8'h00;
      trig_q <= 8'h00;
      wait_n = 0;
    end else if (card_op_ready) begin
      card_op_ready <= 1'b0;
    end else if (card_op_valid) begin
      // random latency so that prompt and slow answers both occur
      if (wait_n == 0) wait_n = 1 + $urandom_range(0, 4);
      wait_n--;
      if (wait_n == 0) begin
        card_op_ready <= 1'b1;
        case (card_op_code)
          OP_TRIG_CLR:  trig_q[card_op_slot] <= 1'b0;
          OP_MODE_CFG:  meas_q[card_op_slot] <= 1'b0;
          OP_MODE_MEAS: meas_q[card_op_slot] <= 1'b1;
          default:      trig_q[card_op_slot] <= 1'b1;
        endcase
      end
    end
  end
endmodule

// *** testbench/measurement_start_sequencer_test.sv ***
`timescale 1ns/1ps
`include "seq_map.svh"
module measurement_start_sequencer_test;
  import seq_pkg::*;
  logic        core_clk, bp_clk, sys_rst, bp_clk_en;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, card_op_valid, card_op_ready;
  logic [7:0]  awaddr, araddr, cont_sel, gen, mask, cont;
  logic [31:0] wdata, rdata, card_op_data, loops, cards;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [2:0]  card_op_slot;
  card_op_t    card_op_code;
  logic [2:0]  sl[4];
  logic [36:0] exp_q[$];
  logic        keep;
  int          n_errors, n_tests, n, base;
  int          cnt_t[4] = '{2, 4, 7, 0};

  measurement_start_sequencer dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bp_clk(bp_clk),
    .bp_clk_en(bp_clk_en), .card_op_valid(card_op_valid), .card_op_ready(card_op_ready),
    .card_op_code(card_op_code), .card_op_slot(card_op_slot), .card_op_data(card_op_data),
    .continuous_generate_select(cont_sel));
  card_backplane_model cards_i (
    .bp_clk(bp_clk), .sys_rst(sys_rst), .card_op_valid(card_op_valid), .card_op_code(card_op_code),
    .card_op_slot(card_op_slot), .cont_sel(cont_sel), .card_op_ready(card_op_ready), .gen(gen));

  // ====
  // clocks, checking and closing
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    bp_clk = 1'b0;
    #3.7;
    forever #6 bp_clk = ~bp_clk;
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t ns: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #1_000_000;
    n_errors++;
    $display("unexpected at %0t ns: watchdog expired", $time);
    wrap_up();
  end

  // ====
  // register bus master
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_done, w_done;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_done = 1'b0;
    w_done = 1'b0;
    forever begin
      @(posedge core_clk);
      if (!aw_done && awready) begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (!w_done && wready) begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
      if (bvalid) break;
    end
    bready <= 1'b0;
    check(64'(bresp), 64'(er));
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    check(64'(rdata), 64'(ed));
    check(64'(rresp), 64'(er));
  endtask

  // ====
  // card operation notes and their monitor
  task automatic push_list(input card_op_t c, input logic rev);
    int k, i;
    for (k = 0; k < n; k++) begin
      i = rev ? n - 1 - k : k;
      // continuous cards get no loop counts
      exp_q.push_back({c, sl[i], (c == OP_MODE_MEAS && !cont[sl[i]]) ? loops : 32'h0});
    end
  endtask
  task automatic drain();
    int i;
    for (i = 0; i < 4000 && exp_q.size() > 0; i++) @(posedge core_clk);
    repeat (20) @(posedge core_clk);
    check(64'(exp_q.size()), 64'h0);
  endtask
  always @(posedge bp_clk) begin
    if (!sys_rst && card_op_valid && card_op_ready) begin
      check(64'(bp_clk_en), 64'h1);
      if (exp_q.size() == 0) check(64'h1, 64'h0);
      else check(64'({card_op_code, card_op_slot, card_op_data}), 64'(exp_q.pop_front()));
    end
  end

  // ====
  // main sequence
  initial begin
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
    n_errors = 0;
    n_tests = 0;
    void'($urandom(32'hb0465df8));
    sys_rst = 1'b1;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    foreach (cnt_t[k]) axi_rd(8'(4 * k), 32'h0, `RESP_OKAY);
    axi_rd(`REG_LOOPS, `LOOPS_RST, `RESP_OKAY);
    axi_rd(8'h14, 32'h0, `RESP_SLVERR);
    axi_wr(8'h20, 32'h0, `RESP_SLVERR);
    for (int t = 0; t < 4; t++) begin
      n = cnt_t[t] > 4 ? 4 : cnt_t[t];
      keep = (t == 2) ? 1'($urandom) : 1'(t % 2);
      loops = $urandom;
      base = $urandom_range(0, 7);
      cards = 32'(cnt_t[t]) << `CARDS_CNT_LSB;
      mask = 8'h00;
      for (int k = 0; k < 4; k++) begin
        sl[k] = 3'(base + 3 * k);
        cards = cards | (32'(sl[k]) << (3 * k));
        if (k < n) mask[sl[k]] = 1'b1;
      end
      cont = 8'($urandom_range(0, 255));
      axi_wr(`REG_LOOPS, loops, `RESP_OKAY);
      axi_wr(`REG_CONT, {24'h0, cont}, `RESP_OKAY);
      axi_wr(`REG_CARDS, cards, `RESP_OKAY);
      check(64'(cont_sel), 64'(cont));
      push_list(OP_TRIG_CLR, 1'b0);
      push_list(OP_MODE_CFG, 1'b0);
      push_list(OP_MODE_MEAS, 1'b1);
      push_list(OP_TRIG_SET, 1'b1);
      axi_wr(`REG_CTRL, {30'h0, keep, 1'b1}, `RESP_OKAY);
      drain();
      axi_rd(`REG_STATUS, {30'h0, keep, 1'b1}, `RESP_OKAY);
      axi_rd(`REG_CTRL, {30'h0, keep, 1'b1}, `RESP_OKAY);
      check(64'(bp_clk_en), 64'(keep));
      check(64'(gen), 64'(cont & mask));
      push_list(OP_TRIG_CLR, 1'b0);
      push_list(OP_MODE_CFG, 1'b0);
      axi_wr(`REG_CTRL, 32'h0, `RESP_OKAY);
      drain();
      axi_rd(`REG_STATUS, 32'h2, `RESP_OKAY);
      check(64'(bp_clk_en), 64'h1);
      check(64'(gen), 64'h0);
    end
    wrap_up();
  end
endmodule
